// >>> rtl/ldl_consts.svh
// constants for the link debug and loopback control block
`ifndef LDL_CONSTS_SVH
`define LDL_CONSTS_SVH

`define LDL_LB_NONE 2'b00
`define LDL_LB_SERIAL 2'b01
`define LDL_LB_PAR_STITCH 2'b10
`define LDL_LB_PAR_DIRECT 2'b11
`define LDL_REV_NONE 4'h0
`define LDL_REV_W 4
`define LDL_BYTES 4
`define LDL_SYNC_LOCK_CNT 3'h4

`endif

// >>> rtl/ldl_link_debug_loopback_ctrl.sv
// link status reporting, loopback selection and slave sync override
//
// Behaviour
// - rx_cdr_data_lock_out shows the recovery lock onto incoming data, always present.
// - with debug_enable_in high the further status outputs are driven, otherwise zero.
// - rx_cdr_ref_lock_out shows the recovery lock to the reference clock.
// - rx_code_err_out bit n flags an invalid 8b/10b code group in byte n.
// - rx_disp_err_out bit n flags a disparity error in byte n.
// - rx_block_header_error_out flags an invalid 64b/66b sync header.
// - forward select 2'b01 with the serial option loops the PMA serial path.
// - forward 2'b10 loops in parallel with stitching, 2'b11 without it.
// - a non-zero reverse field loops the selected received portions to transmit.
// - unselected portions during reverse loopback carry local transmit content.
// - a slave without transmit force sends no sync characters until its receiver has locked.
// - with transmit force set, a slave sends sync characters before lock.
`timescale 1ns/10ps
`include "ldl_consts.svh"
module ldl_link_debug_loopback_ctrl
    import ldl_pkg::*;
(
    input wire logic clock_in,
    input wire logic rst_in,
    // option straps, fixed per build
    input wire logic debug_enable_in,
    input wire logic serial_lb_option_in,
    input wire logic parallel_lb_option_in,
    input wire logic reverse_lb_option_in,
    // control fields
    input wire logic [1:0] loop_forward_in,
    input wire logic [`LDL_REV_W-1:0] loop_reversed_in,
    input wire logic tx_force_in,
    input wire logic master_role_in,
    // asynchronous transceiver status
    input wire logic pma_data_lock_in,
    input wire logic pma_ref_lock_in,
    input wire logic [`LDL_BYTES-1:0] pma_code_err_in,
    input wire logic [`LDL_BYTES-1:0] pma_disp_err_in,
    input wire logic pma_block_header_error_in,
    // receiver sync-character lock from the framer, same clock
    input wire logic rx_sync_lock_in,
    // status outputs
    output logic rx_cdr_data_lock_out,
    output logic rx_cdr_ref_lock_out,
    output logic [`LDL_BYTES-1:0] rx_code_err_out,
    output logic [`LDL_BYTES-1:0] rx_disp_err_out,
    output logic rx_block_header_error_out,
    // loopback controls toward the datapath
    output logic serial_lb_en_out,
    output logic par_lb_stitch_en_out,
    output logic par_lb_direct_en_out,
    output logic [`LDL_REV_W-1:0] rev_lb_sel_out,
    output logic [`LDL_REV_W-1:0] local_fill_sel_out,
    output logic normal_mode_out,
    output logic tx_sync_enable_out
);

    // ----------------------------------------------------------------
    // status synchronisers
    // ----------------------------------------------------------------
    // every status line is asynchronous, so each group passes two flops
    logic s_data_lock;
    logic s_ref_lock;
    logic [`LDL_BYTES-1:0] s_code_err;
    logic [`LDL_BYTES-1:0] s_disp_err;
    logic s_hdr_err;

    ldl_sync2 #(
        .WIDTH(1)
    ) u_sync_data_lock (
        .clock_in(clock_in),
        .rst_in(rst_in),
        .async_in(pma_data_lock_in),
        .sync_out(s_data_lock)
    );

    ldl_sync2 #(
        .WIDTH(1)
    ) u_sync_ref_lock (
        .clock_in(clock_in),
        .rst_in(rst_in),
        .async_in(pma_ref_lock_in),
        .sync_out(s_ref_lock)
    );

    // per-byte flags may tear by a cycle; they are debug levels, not data
    ldl_sync2 #(
        .WIDTH(`LDL_BYTES)
    ) u_sync_code_err (
        .clock_in(clock_in),
        .rst_in(rst_in),
        .async_in(pma_code_err_in),
        .sync_out(s_code_err)
    );

    ldl_sync2 #(
        .WIDTH(`LDL_BYTES)
    ) u_sync_disp_err (
        .clock_in(clock_in),
        .rst_in(rst_in),
        .async_in(pma_disp_err_in),
        .sync_out(s_disp_err)
    );

    ldl_sync2 #(
        .WIDTH(1)
    ) u_sync_hdr_err (
        .clock_in(clock_in),
        .rst_in(rst_in),
        .async_in(pma_block_header_error_in),
        .sync_out(s_hdr_err)
    );

    // ----------------------------------------------------------------
    // lock indications
    // ----------------------------------------------------------------
    logic data_lock_q;
    logic data_lock_d;
    logic ref_lock_q;
    logic ref_lock_d;

    always_comb begin
        data_lock_d = s_data_lock;
        ref_lock_d = 1'b0;
        // reference lock belongs to the optional debug set
        if (debug_enable_in) begin
            ref_lock_d = s_ref_lock;
        end
    end

    always_ff @(posedge clock_in or posedge rst_in) begin
        if (rst_in) begin
            data_lock_q <= 1'b0;
            ref_lock_q <= 1'b0;
        end else begin
            data_lock_q <= data_lock_d;
            ref_lock_q <= ref_lock_d;
        end
    end

    assign rx_cdr_data_lock_out = data_lock_q;
    assign rx_cdr_ref_lock_out = ref_lock_q;

    // ----------------------------------------------------------------
    // receive error flags
    // ----------------------------------------------------------------
    logic [`LDL_BYTES-1:0] code_err_q;
    logic [`LDL_BYTES-1:0] code_err_d;
    logic [`LDL_BYTES-1:0] disp_err_q;
    logic [`LDL_BYTES-1:0] disp_err_d;
    logic hdr_err_q;
    logic hdr_err_d;

    always_comb begin
        code_err_d = '0;
        disp_err_d = '0;
        hdr_err_d = 1'b0;
        // flags read as zero while the debug option is off
        if (debug_enable_in) begin
            code_err_d = s_code_err;
            disp_err_d = s_disp_err;
            hdr_err_d = s_hdr_err;
        end
    end

    always_ff @(posedge clock_in or posedge rst_in) begin
        if (rst_in) begin
            code_err_q <= '0;
            disp_err_q <= '0;
            hdr_err_q <= 1'b0;
        end else begin
            code_err_q <= code_err_d;
            disp_err_q <= disp_err_d;
            hdr_err_q <= hdr_err_d;
        end
    end

    assign rx_code_err_out = code_err_q;
    assign rx_disp_err_out = disp_err_q;
    assign rx_block_header_error_out = hdr_err_q;

    // ----------------------------------------------------------------
    // forward loopback selection
    // ----------------------------------------------------------------
    logic ser_q;
    logic ser_d;
    logic pst_q;
    logic pst_d;
    logic pdi_q;
    logic pdi_d;

    always_comb begin
        ser_d = 1'b0;
        pst_d = 1'b0;
        pdi_d = 1'b0;
        // a select for an option not built is ignored
        case (loop_forward_in)
            `LDL_LB_SERIAL: ser_d = serial_lb_option_in;
            `LDL_LB_PAR_STITCH: pst_d = parallel_lb_option_in;
            `LDL_LB_PAR_DIRECT: pdi_d = parallel_lb_option_in;
            default: ser_d = 1'b0;
        endcase
    end

    always_ff @(posedge clock_in or posedge rst_in) begin
        if (rst_in) begin
            ser_q <= 1'b0;
            pst_q <= 1'b0;
            pdi_q <= 1'b0;
        end else begin
            ser_q <= ser_d;
            pst_q <= pst_d;
            pdi_q <= pdi_d;
        end
    end

    assign serial_lb_en_out = ser_q;
    assign par_lb_stitch_en_out = pst_q;
    assign par_lb_direct_en_out = pdi_q;

    // ----------------------------------------------------------------
    // reverse loopback selection
    // ----------------------------------------------------------------
    logic [`LDL_REV_W-1:0] rev_q;
    logic [`LDL_REV_W-1:0] rev_d;
    logic [`LDL_REV_W-1:0] fill_q;
    logic [`LDL_REV_W-1:0] fill_d;

    always_comb begin
        rev_d = reverse_lb_option_in ? loop_reversed_in : `LDL_REV_NONE;
        // portions not looped come from local transmit content
        fill_d = ~rev_d;
    end

    always_ff @(posedge clock_in or posedge rst_in) begin
        if (rst_in) begin
            rev_q <= `LDL_REV_NONE;
            fill_q <= {`LDL_REV_W{1'b1}};
        end else begin
            rev_q <= rev_d;
            fill_q <= fill_d;
        end
    end

    assign rev_lb_sel_out = rev_q;
    assign local_fill_sel_out = fill_q;

    // ----------------------------------------------------------------
    // normal operation flag
    // ----------------------------------------------------------------
    logic norm_q;
    logic norm_d;

    always_comb begin
        // judged on next values so the flag moves in step with the paths
        norm_d = !(ser_d || pst_d || pdi_d) && (rev_d == `LDL_REV_NONE);
    end

    always_ff @(posedge clock_in or posedge rst_in) begin
        if (rst_in) begin
            norm_q <= 1'b1;
        end else begin
            norm_q <= norm_d;
        end
    end

    assign normal_mode_out = norm_q;

    // ----------------------------------------------------------------
    // transmit sync-character enable
    // ----------------------------------------------------------------
    ldl_sync_state_t st_q;
    ldl_sync_state_t st_d;
    logic tx_en_q;
    logic tx_en_d;

    // master always transmits; a slave waits for lock unless forced,
    // and falls back to waiting if lock and force are both lost
    always_comb begin
        st_d = st_q;
        case (st_q)
            LDL_SYNC_IDLE: begin
                if (master_role_in || rx_sync_lock_in || tx_force_in) begin
                    st_d = LDL_SYNC_SEND;
                end
            end
            LDL_SYNC_SEND: begin
                if (!master_role_in && !rx_sync_lock_in && !tx_force_in) begin
                    st_d = LDL_SYNC_IDLE;
                end
            end
            default: st_d = LDL_SYNC_IDLE;
        endcase
        tx_en_d = (st_d == LDL_SYNC_SEND);
    end

    always_ff @(posedge clock_in or posedge rst_in) begin
        if (rst_in) begin
            st_q <= LDL_SYNC_IDLE;
            tx_en_q <= 1'b0;
        end else begin
            st_q <= st_d;
            tx_en_q <= tx_en_d;
        end
    end

    assign tx_sync_enable_out = tx_en_q;

endmodule // ldl_link_debug_loopback_ctrl

// >>> rtl/ldl_pkg.sv
// types for the link debug and loopback control block
package ldl_pkg;
    typedef enum logic [1:0] {
        LDL_SYNC_IDLE = 2'b00,
        LDL_SYNC_SEND = 2'b01
    } ldl_sync_state_t;
endpackage

// >>> rtl/ldl_sync2.sv
// two-flop synchroniser for a group of asynchronous levels
`timescale 1ns/10ps
module ldl_sync2 #(
    parameter int WIDTH = 1
) (
    input wire logic clock_in,
    input wire logic rst_in,
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);
    // bits are not kept coherent: one may land a cycle before another
    logic [WIDTH-1:0] meta_q;
    logic [WIDTH-1:0] meta_d;
    logic [WIDTH-1:0] sync_q;
    logic [WIDTH-1:0] sync_d;

    always_comb begin
        meta_d = async_in;
        sync_d = meta_q;
    end

    always_ff @(posedge clock_in or posedge rst_in) begin
        if (rst_in) begin
            meta_q <= '0;
            sync_q <= '0;
        end else begin
            meta_q <= meta_d;
            sync_q <= sync_d;
        end
    end

    assign sync_out = sync_q;
endmodule // ldl_sync2

// >>> sim/ldl_loopback_checker.sv
// port-level assertions for the link debug and loopback control block
`timescale 1ns/10ps
module ldl_loopback_checker (
    input logic clock_in,
    input logic rst_in,
    input logic debug_enable_in,
    input logic serial_lb_option_in,
    input logic parallel_lb_option_in,
    input logic reverse_lb_option_in,
    input logic [1:0] loop_forward_in,
    input logic [3:0] loop_reversed_in,
    input logic tx_force_in,
    input logic master_role_in,
    input logic rx_sync_lock_in,
    input logic pma_data_lock_in,
    input logic [3:0] pma_code_err_in,
    input logic rx_cdr_data_lock_out,
    input logic rx_cdr_ref_lock_out,
    input logic [3:0] rx_code_err_out,
    input logic [3:0] rx_disp_err_out,
    input logic rx_block_header_error_out,
    input logic serial_lb_en_out,
    input logic par_lb_stitch_en_out,
    input logic par_lb_direct_en_out,
    input logic [3:0] rev_lb_sel_out,
    input logic [3:0] local_fill_sel_out,
    input logic normal_mode_out,
    input logic tx_sync_enable_out
);
    default clocking cb @(posedge clock_in); endclocking
    default disable iff (rst_in);
    chk_serial_map: assert property (!$past(rst_in) |-> serial_lb_en_out ==
        $past(serial_lb_option_in && loop_forward_in == 2'b01)) else $error("serial map");
    chk_par_map: assert property (!$past(rst_in) |-> {par_lb_stitch_en_out,
        par_lb_direct_en_out} == $past({parallel_lb_option_in && loop_forward_in == 2'b10,
        parallel_lb_option_in && loop_forward_in == 2'b11})) else $error("parallel map");
    chk_rev_sel: assert property (!$past(rst_in) |-> rev_lb_sel_out ==
        ($past(reverse_lb_option_in) ? $past(loop_reversed_in) : 4'h0)) else $error("rev sel");
    chk_fill_inverse: assert property (local_fill_sel_out == ~rev_lb_sel_out)
        else $error("fill sel");
    chk_normal_idle: assert property (normal_mode_out == !(serial_lb_en_out ||
        par_lb_stitch_en_out || par_lb_direct_en_out || rev_lb_sel_out != 4'h0))
        else $error("normal mode");
    chk_slave_wait: assert property (!$past(rst_in) &&
        !$past(master_role_in || tx_force_in || rx_sync_lock_in) |-> !tx_sync_enable_out)
        else $error("slave sync early");
    chk_force_send: assert property (!$past(rst_in) && $past(tx_force_in) |->
        tx_sync_enable_out) else $error("force sync");
    chk_data_lock: assert property ($stable(pma_data_lock_in) [*4] |->
        rx_cdr_data_lock_out == pma_data_lock_in) else $error("data lock");
    chk_code_flags: assert property ((debug_enable_in && $stable(pma_code_err_in)) [*4]
        |-> rx_code_err_out == pma_code_err_in) else $error("code flags");
    chk_debug_off: assert property (!$past(rst_in) && !$past(debug_enable_in) |->
        {rx_cdr_ref_lock_out, rx_code_err_out, rx_disp_err_out, rx_block_header_error_out}
        == 10'h0) else $error("debug status not zero");
    cover property (serial_lb_en_out);
    cover property (par_lb_direct_en_out);
    cover property (rev_lb_sel_out != 4'h0 && !master_role_in && tx_sync_enable_out);
    cover property (rx_code_err_out != 4'h0);
    cover property (!master_role_in && tx_force_in && !rx_sync_lock_in ##1 tx_sync_enable_out);
endmodule // ldl_loopback_checker
bind ldl_link_debug_loopback_ctrl ldl_loopback_checker u_chk (
    .clock_in(clock_in), .rst_in(rst_in), .debug_enable_in(debug_enable_in),
    .serial_lb_option_in(serial_lb_option_in), .parallel_lb_option_in(parallel_lb_option_in),
    .reverse_lb_option_in(reverse_lb_option_in), .loop_forward_in(loop_forward_in),
    .loop_reversed_in(loop_reversed_in), .tx_force_in(tx_force_in),
    .master_role_in(master_role_in), .rx_sync_lock_in(rx_sync_lock_in),
    .pma_data_lock_in(pma_data_lock_in), .pma_code_err_in(pma_code_err_in),
    .rx_cdr_data_lock_out(rx_cdr_data_lock_out), .rx_cdr_ref_lock_out(rx_cdr_ref_lock_out),
    .rx_code_err_out(rx_code_err_out), .rx_disp_err_out(rx_disp_err_out),
    .rx_block_header_error_out(rx_block_header_error_out),
    .serial_lb_en_out(serial_lb_en_out), .par_lb_stitch_en_out(par_lb_stitch_en_out),
    .par_lb_direct_en_out(par_lb_direct_en_out), .rev_lb_sel_out(rev_lb_sel_out),
    .local_fill_sel_out(local_fill_sel_out), .normal_mode_out(normal_mode_out),
    .tx_sync_enable_out(tx_sync_enable_out)
);

// >>> sim/ldl_pma_peer.sv
// link peer model driving the asynchronous transceiver status lines
`timescale 1ns/10ps
module ldl_pma_peer (
    output logic lock_out,
    output logic ref_out,
    output logic hdr_out,
    output logic [3:0] code_out,
    output logic [3:0] disp_out
);
    // tx pma clock is left to an outside pll at line rate, not modelled
    initial {lock_out, ref_out, hdr_out, code_out, disp_out} = 11'h0;
    // skew lands changes off the sampling edge, like a recovered-clock source
    task automatic drive(input logic [10:0] v, input int unsigned skew);
        #(skew);
        {lock_out, ref_out, hdr_out, code_out, disp_out} = v;
    endtask
endmodule // ldl_pma_peer

// >>> sim/tb.sv
// self-checking bench for the link debug and loopback control block
`timescale 1ns/10ps
module tb;
    logic clock_in = 1'b0;
    logic rst_in = 1'b1;
    logic dbg, sopt, popt, ropt, frc, mst, slk, pdl, prl, pbh;
    logic dl_o, rl_o, bh_o, ser_o, pst_o, pdi_o, nrm_o, tse_o;
    logic [1:0] fwd;
    logic [2:0] ex;
    logic [3:0] rev, erev, pce, pde, ce_o, de_o, rev_o, fill_o;
    logic [10:0] stv;
    logic [11:0] est;
    int unsigned exp_q[$];
    int num_errors = 0;
    int num_checks = 0;
    int cyc = 0;
    ldl_pma_peer u_peer (.lock_out(pdl), .ref_out(prl), .hdr_out(pbh), .code_out(pce),
        .disp_out(pde));
    ldl_link_debug_loopback_ctrl u_dut (.clock_in(clock_in), .rst_in(rst_in),
        .debug_enable_in(dbg), .serial_lb_option_in(sopt), .parallel_lb_option_in(popt),
        .reverse_lb_option_in(ropt), .loop_forward_in(fwd), .loop_reversed_in(rev),
        .tx_force_in(frc), .master_role_in(mst), .pma_data_lock_in(pdl),
        .pma_ref_lock_in(prl), .pma_code_err_in(pce), .pma_disp_err_in(pde),
        .pma_block_header_error_in(pbh), .rx_sync_lock_in(slk), .rx_cdr_data_lock_out(dl_o),
        .rx_cdr_ref_lock_out(rl_o), .rx_code_err_out(ce_o), .rx_disp_err_out(de_o),
        .rx_block_header_error_out(bh_o), .serial_lb_en_out(ser_o),
        .par_lb_stitch_en_out(pst_o), .par_lb_direct_en_out(pdi_o), .rev_lb_sel_out(rev_o),
        .local_fill_sel_out(fill_o), .normal_mode_out(nrm_o), .tx_sync_enable_out(tse_o));
    initial forever #12.5 clock_in = ~clock_in;
    // about 1100 cycles expected, so 3000 means a hang
    always @(posedge clock_in) begin
        cyc <= cyc + 1;
        if (cyc == 3000) begin
            num_errors++;
            final_report();
        end
    end
    task automatic chk(input logic [11:0] g, input logic [11:0] e);
        num_checks++;
        if (g !== e) begin
            num_errors++;
            $display("mismatch t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask
    task automatic final_report();
        $display("errors=%0d checks=%0d", num_errors, num_checks);
        if (num_errors == 0 && num_checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    initial begin
        {dbg, sopt, popt, ropt, fwd, rev, frc, mst, slk} = 13'h0;
        void'($urandom(32'h501dad77));
        repeat (3) @(negedge clock_in);
        chk({3'h0, ser_o, pst_o, pdi_o, nrm_o, tse_o, fill_o}, 12'h02f);
        rst_in = 1'b0;
        // controls change every other cycle, all codes and roles drawn at random
        repeat (300) begin
            @(negedge clock_in);
            {sopt, popt, ropt, fwd, rev, frc, mst, slk} = 12'($urandom);
            @(negedge clock_in);
            erev = ropt ? rev : 4'h0;
            ex = {sopt && fwd == 2'b01, popt && fwd == 2'b10, popt && fwd == 2'b11};
            chk({8'h0, ser_o, pst_o, pdi_o, nrm_o}, {8'h0, ex, ~|{ex, erev}});
            chk({4'h0, rev_o, fill_o}, {4'h0, erev, ~erev});
            chk({11'h0, tse_o}, {11'h0, mst | frc | slk});
        end
        // slave in external loopback: force is set first, lock follows later
        {mst, frc, slk} = 3'b010;
        @(negedge clock_in);
        chk({11'h0, tse_o}, 12'h001);
        {mst, frc, slk} = 3'b000;
        @(negedge clock_in);
        chk({11'h0, tse_o}, 12'h000);
        slk = 1'b1;
        @(negedge clock_in);
        chk({11'h0, tse_o}, 12'h001);
        // status changes asynchronously; allow the synchroniser latency first
        repeat (100) begin
            @(negedge clock_in);
            dbg = 1'($urandom);
            stv = 11'($urandom);
            exp_q.push_back({1'b0, stv[10], dbg ? stv[9:0] : 10'h0});
            u_peer.drive(stv, 1 + $urandom % 20);
            repeat (4) @(negedge clock_in);
            est = 12'(exp_q.pop_front());
            chk({1'b0, dl_o, rl_o, bh_o, ce_o, de_o}, est);
        end
        // mid-run reset clears all but the normal flag and fill selects; status returns after the latency
        rst_in = 1'b1;
        @(negedge clock_in);
        chk({3'h0, ser_o, pst_o, pdi_o, nrm_o, tse_o, fill_o}, 12'h02f);
        chk({1'b0, dl_o, rl_o, bh_o, ce_o, de_o}, 12'h000);
        rst_in = 1'b0;
        repeat (4) @(negedge clock_in);
        chk({1'b0, dl_o, rl_o, bh_o, ce_o, de_o}, est);
        chk({11'h0, tse_o}, 12'h001);
        final_report();
    end
endmodule // tb
